// ---- logic/oag_pkg.sv ----
// Shared constants and types for the operand address generator
package oag_pkg;
   localparam logic [7:0]  ZERO_PAGE_HI  = 8'h00;
   localparam logic [7:0]  BANK_PAGE_HI  = 8'h01;
   localparam logic [15:0] VEC_BASE      = 16'hFFC0;
   localparam int          BANK_REG_SHIFT = 3;
   localparam int          BIT_SEL_W     = 3;
   localparam int          BANK_PTR_W    = 5;
   localparam logic [7:0]  CCR_RESET     = 8'h00;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam int          FLAG_N        = 3;
   localparam int          FLAG_Z        = 2;
   localparam int          FLAG_V        = 1;
   localparam int          FLAG_C        = 0;

   typedef enum logic [9:0] {
      OAG_DIRECT   = 10'h001,
      OAG_EXTENDED = 10'h002,
      OAG_BITDIR   = 10'h004,
      OAG_INDEX    = 10'h008,
      OAG_POINTER  = 10'h010,
      OAG_BANKREG  = 10'h020,
      OAG_IMMED    = 10'h040,
      OAG_VECTOR   = 10'h080,
      OAG_RELATIVE = 10'h100,
      OAG_INHERENT = 10'h200
   } oag_mode_t;
endpackage

// ---- logic/oag_bit_modify.sv ----
// Read-modify-write bit setter/clearer for bit manipulation
`timescale 1ns/1ps
module oag_bit_modify (
   // Byte read from memory
   input  wire logic [7:0] rd_data_i,
   // Bit select and operation
   input  wire logic [2:0] bit_sel_i,
   input  wire logic       set_bit_i,
   // Byte to write back
   output logic      [7:0] wr_data_o
);
   always_comb begin
      wr_data_o = rd_data_i;
      wr_data_o[bit_sel_i] = set_bit_i;
   end
endmodule

// ---- logic/oag_core.sv ----
// Operand address generation, core pointer registers and flag update
`timescale 1ns/1ps

// How it works
// - Direct: address high byte zero, low operand
// - Extended: first operand high, second low
// - Bit direct: page zero, bit from opcode
// - Indexed: index plus sign-extended displacement
// - Pointer: extra pointer is the address
// - Bank register: page 01, pointer and opcode
// - Immediate: operands are data, imm_word_i sizes
// - Vector: target from FFC0+2n table pair
// - Vector call pushes next-instruction return address
// - Relative: PC plus signed operand byte
// - One-byte opcode plus zero or more operands
// - Accumulator copied to temporary when instructed
// - Core holds pointer, flag and bank registers
// - Accumulators usable as 8 or 16 bits
// - Bit operand 8:3 bits, long address 16
// - Bit set/clear is read-modify-write byte
// - Flags change only where instruction marks them
module oag_core (
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    sys_rst_i,
   // Decoded instruction
   input  wire logic                    exec_i,
   input  wire oag_pkg::oag_mode_t      mode_i,
   input  wire logic [7:0]              opcode_i,
   input  wire logic [7:0]              operand1_i,
   input  wire logic [7:0]              operand2_i,
   input  wire logic                    imm_word_i,
   input  wire logic [15:0]             next_pc_i,
   // Register writes from the execution unit
   input  wire logic                    acc_hi_we_i,
   input  wire logic                    acc_lo_we_i,
   input  wire logic [15:0]             acc_wdata_i,
   input  wire logic                    temp_hi_copy_i,
   input  wire logic                    temp_lo_copy_i,
   input  wire logic                    index_we_i,
   input  wire logic                    extra_we_i,
   input  wire logic                    stack_we_i,
   input  wire logic [15:0]             ptr_wdata_i,
   input  wire logic                    bank_we_i,
   input  wire logic [4:0]              bank_wdata_i,
   input  wire logic                    gpr_we_i,
   input  wire logic [7:0]              gpr_wdata_i,
   input  wire logic                    branch_taken_i,
   input  wire logic [15:0]             vector_target_i,
   input  wire logic                    vector_load_i,
   // Flag update
   input  wire logic [3:0]              flag_change_i,
   input  wire logic [3:0]              flag_value_i,
   // Bit manipulation
   input  wire logic [7:0]              rmw_rd_data_i,
   output logic      [7:0]              rmw_wr_data_o,
   // Address and data results
   output logic      [15:0]             eff_addr_o,
   output logic      [2:0]              bit_sel_o,
   output logic      [15:0]             imm_data_o,
   output logic      [15:0]             vec_addr_hi_o,
   output logic      [15:0]             vec_addr_lo_o,
   output logic      [15:0]             push_addr_o,
   output logic      [15:0]             push_data_o,
   output logic                         push_o,
   // Register views
   output logic      [15:0]             pc_o,
   output logic      [15:0]             acc_o,
   output logic      [15:0]             temp_o,
   output logic      [15:0]             index_register_o,
   output logic      [15:0]             extra_pointer_o,
   output logic      [15:0]             stack_top_pointer_o,
   output logic      [7:0]              condition_flags_o,
   output logic      [4:0]              bank_select_pointer_o,
   output logic      [7:0]              bank_gpr_o
);
   logic [15:0] pc;
   logic [7:0]  acc_high;
   logic [7:0]  acc_low;
   logic [7:0]  temp_high;
   logic [7:0]  temp_low;
   logic [15:0] index_register;
   logic [15:0] extra_pointer;
   logic [15:0] stack_top_pointer;
   logic [7:0]  condition_flags;
   logic [4:0]  bank_select_pointer;
   logic [7:0]  bank_general_regs [8];
   logic [15:0] next_addr;
   logic [15:0] rel_target;
   logic        is_vector;

   // Eight registers per bank, so the low byte is pointer*8 plus index
   function automatic logic [7:0] bank_low(input logic [4:0] bp, input logic [2:0] ri);
      bank_low = {bp, ri};
   endfunction

   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   assign rel_target = pc + sext8(operand1_i);
   assign is_vector  = exec_i && (mode_i == oag_pkg::OAG_VECTOR);

   ////////////////////////////////////////////////////////////////////////
   // Effective address per mode
   always_comb begin
      next_addr = oag_pkg::WORD_RESET;
      unique case (mode_i)
         oag_pkg::OAG_DIRECT:   next_addr = {oag_pkg::ZERO_PAGE_HI, operand1_i};
         oag_pkg::OAG_EXTENDED: next_addr = {operand1_i, operand2_i};
         oag_pkg::OAG_BITDIR:   next_addr = {oag_pkg::ZERO_PAGE_HI, operand1_i};
         oag_pkg::OAG_INDEX:    next_addr = index_register + sext8(operand1_i);
         oag_pkg::OAG_POINTER:  next_addr = extra_pointer;
         oag_pkg::OAG_BANKREG:  next_addr = {oag_pkg::BANK_PAGE_HI,
                                             bank_low(bank_select_pointer, opcode_i[2:0])};
         oag_pkg::OAG_VECTOR:   next_addr = oag_pkg::VEC_BASE + {12'h000, opcode_i[2:0], 1'b0};
         oag_pkg::OAG_RELATIVE: next_addr = rel_target;
         oag_pkg::OAG_IMMED:    next_addr = pc;
         oag_pkg::OAG_INHERENT: next_addr = pc;
         default:               next_addr = oag_pkg::WORD_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered address outputs, only on an executed instruction
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         eff_addr_o    <= oag_pkg::WORD_RESET;
         bit_sel_o     <= 3'h0;
         imm_data_o    <= oag_pkg::WORD_RESET;
         vec_addr_hi_o <= oag_pkg::WORD_RESET;
         vec_addr_lo_o <= oag_pkg::WORD_RESET;
      end else if (exec_i) begin
         eff_addr_o    <= next_addr;
         bit_sel_o     <= opcode_i[oag_pkg::BIT_SEL_W-1:0];
         imm_data_o    <= imm_word_i ? {operand1_i, operand2_i} : {8'h00, operand1_i};
         vec_addr_hi_o <= next_addr;
         vec_addr_lo_o <= next_addr + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return address push on a vector call
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         push_o      <= 1'b0;
         push_addr_o <= oag_pkg::WORD_RESET;
         push_data_o <= oag_pkg::WORD_RESET;
      end else begin
         push_o <= is_vector;
         if (is_vector) begin
            push_addr_o <= stack_top_pointer;
            push_data_o <= next_pc_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program counter: vector load wins over relative branch, then fall-through
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pc <= oag_pkg::WORD_RESET;
      end else if (vector_load_i) begin
         pc <= vector_target_i;
      end else if (exec_i && branch_taken_i && mode_i == oag_pkg::OAG_RELATIVE) begin
         pc <= rel_target;
      end else if (exec_i) begin
         pc <= next_pc_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator and temporary accumulator halves
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         acc_high  <= 8'h00;
         acc_low   <= 8'h00;
         temp_high <= 8'h00;
         temp_low  <= 8'h00;
      end else begin
         // Copy takes the old accumulator, before this cycle's write lands
         if (temp_hi_copy_i) temp_high <= acc_high;
         if (temp_lo_copy_i) temp_low  <= acc_low;
         if (acc_hi_we_i) acc_high <= acc_wdata_i[15:8];
         if (acc_lo_we_i) acc_low  <= acc_wdata_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pointer registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         index_register      <= oag_pkg::WORD_RESET;
         extra_pointer       <= oag_pkg::WORD_RESET;
         stack_top_pointer   <= oag_pkg::WORD_RESET;
         bank_select_pointer <= 5'h00;
      end else begin
         if (index_we_i) index_register <= ptr_wdata_i;
         if (extra_we_i) extra_pointer  <= ptr_wdata_i;
         if (stack_we_i) stack_top_pointer <= ptr_wdata_i;
         if (bank_we_i)  bank_select_pointer <= bank_wdata_i;
      end
   end

   // Visible bank registers are one set of eight, selected by opcode_i[2:0] and not by the bank pointer; the bank RAM itself is outside
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bank
         always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
               bank_general_regs[gi] <= 8'h00;
            end else if (gpr_we_i && opcode_i[2:0] == 3'(gi)) begin
               bank_general_regs[gi] <= gpr_wdata_i;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Flags: only marked flags change
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         condition_flags <= oag_pkg::CCR_RESET;
      end else if (exec_i) begin
         for (int i = 0; i < 4; i++) begin
            if (flag_change_i[i]) condition_flags[i] <= flag_value_i[i];
         end
      end
   end

   oag_bit_modify u_bit_modify (
      .rd_data_i (rmw_rd_data_i),
      .bit_sel_i (bit_sel_o),
      .set_bit_i (opcode_i[3]),
      .wr_data_o (rmw_wr_data_o)
   );

   assign pc_o                  = pc;
   assign acc_o                 = {acc_high, acc_low};
   assign temp_o                = {temp_high, temp_low};
   assign index_register_o      = index_register;
   assign extra_pointer_o       = extra_pointer;
   assign stack_top_pointer_o   = stack_top_pointer;
   assign condition_flags_o     = condition_flags;
   assign bank_select_pointer_o = bank_select_pointer;
   assign bank_gpr_o            = bank_general_regs[opcode_i[2:0]];

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_direct_page: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_DIRECT |=> eff_addr_o == {8'h00, $past(operand1_i)})
      else $error("direct address wrong");
   a_extended_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_EXTENDED |=> eff_addr_o == {$past(operand1_i), $past(operand2_i)})
      else $error("extended address wrong");
   a_bit_select: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_BITDIR |=> bit_sel_o == $past(opcode_i[2:0]) && eff_addr_o[15:8] == 8'h00)
      else $error("bit direct wrong");
   a_index_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_INDEX |=>
      eff_addr_o == $past(index_register) + {{8{$past(operand1_i[7])}}, $past(operand1_i)})
      else $error("index address wrong");
   a_pointer_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_POINTER |=> eff_addr_o == $past(extra_pointer))
      else $error("pointer address wrong");
   a_bank_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && mode_i == oag_pkg::OAG_BANKREG |=>
      eff_addr_o == 16'h0100 + 16'($past(bank_select_pointer)) * 16'h0008 + 16'($past(opcode_i[2:0])))
      else $error("bank address wrong");
   a_vector_pair: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      is_vector |=> vec_addr_hi_o == 16'hFFC0 + 16'($past(opcode_i[2:0])) * 16'h0002
      && vec_addr_lo_o == vec_addr_hi_o + 16'h0001)
      else $error("vector table address wrong");
   a_vector_push: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      is_vector |=> push_o && push_addr_o == $past(stack_top_pointer) && push_data_o == $past(next_pc_i))
      else $error("return address not pushed");
   a_rel_branch: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && !vector_load_i && branch_taken_i && mode_i == oag_pkg::OAG_RELATIVE |=>
      pc == $past(pc) + {{8{$past(operand1_i[7])}}, $past(operand1_i)})
      else $error("relative branch wrong");
   a_flag_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !flag_change_i[0] |=> condition_flags[0] == $past(condition_flags[0]))
      else $error("carry changed unmarked");
endmodule

// ---- dv/oag_mem_model.sv ----
// Behavioural model of the core memory seen by the address generator
`timescale 1ns/1ps
module oag_mem_model (
   // Addresses from the generator
   input  wire logic [15:0] eff_addr_i,
   input  wire logic [15:0] vec_addr_hi_i,
   input  wire logic [15:0] vec_addr_lo_i,
   // Data returned
   output logic      [7:0]  rd_data_o,
   output logic      [15:0] vector_target_o
);
   // Contents follow the low address byte, so locations are distinct only within one 256-byte page
   assign rd_data_o       = eff_addr_i[7:0] ^ 8'h3C;
   assign vector_target_o = {vec_addr_hi_i[7:0] + 8'h11, vec_addr_lo_i[7:0] + 8'h11};
endmodule

// ---- dv/cpu_operand_address_gen_tb.sv ----
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module cpu_operand_address_gen_tb;
   logic               mclk_i, sys_rst_i, exec_i, imm_word_i, acc_hi_we_i, acc_lo_we_i, temp_hi_copy_i;
   logic               temp_lo_copy_i, index_we_i, extra_we_i, stack_we_i, bank_we_i, gpr_we_i;
   logic               branch_taken_i, vector_load_i, push_o;
   oag_pkg::oag_mode_t mode_i;
   logic [7:0]         opcode_i, operand1_i, operand2_i, gpr_wdata_i, rmw_rd_data_i, rmw_wr_data_o;
   logic [7:0]         condition_flags_o, bank_gpr_o, rd;
   logic [15:0]        next_pc_i, acc_wdata_i, ptr_wdata_i, vector_target_i, eff_addr_o, imm_data_o;
   logic [15:0]        vec_addr_hi_o, vec_addr_lo_o, push_addr_o, push_data_o, pc_o, acc_o, temp_o;
   logic [15:0]        index_register_o, extra_pointer_o, stack_top_pointer_o;
   logic [4:0]         bank_wdata_i, bank_select_pointer_o;
   logic [3:0]         flag_change_i, flag_value_i;
   logic [2:0]         bit_sel_o;
   int                 miscompares, tests_run;

   oag_core i_oag_core (.mclk_i, .sys_rst_i, .exec_i, .mode_i, .opcode_i, .operand1_i, .operand2_i,
      .imm_word_i, .next_pc_i, .acc_hi_we_i, .acc_lo_we_i, .acc_wdata_i, .temp_hi_copy_i, .temp_lo_copy_i,
      .index_we_i, .extra_we_i, .stack_we_i, .ptr_wdata_i, .bank_we_i, .bank_wdata_i, .gpr_we_i,
      .gpr_wdata_i, .branch_taken_i, .vector_target_i, .vector_load_i, .flag_change_i, .flag_value_i,
      .rmw_rd_data_i, .rmw_wr_data_o, .eff_addr_o, .bit_sel_o, .imm_data_o, .vec_addr_hi_o, .vec_addr_lo_o,
      .push_addr_o, .push_data_o, .push_o, .pc_o, .acc_o, .temp_o, .index_register_o, .extra_pointer_o,
      .stack_top_pointer_o, .condition_flags_o, .bank_select_pointer_o, .bank_gpr_o);
   oag_mem_model i_oag_mem_model (.eff_addr_i(eff_addr_o), .vec_addr_hi_i(vec_addr_hi_o),
      .vec_addr_lo_i(vec_addr_lo_o), .rd_data_o(rmw_rd_data_i), .vector_target_o(vector_target_i));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // One instruction: driven after the first edge, taken at the second, results settle just after it
   task automatic op(input oag_pkg::oag_mode_t m, input logic [7:0] opc, input logic [7:0] o1,
                     input logic [7:0] o2);
      @(posedge mclk_i);
      exec_i <= 1'b1; mode_i <= m; opcode_i <= opc; operand1_i <= o1; operand2_i <= o2;
      @(posedge mclk_i);
      exec_i <= 1'b0; branch_taken_i <= 1'b0; flag_change_i <= 4'h0;
      #1;
   endtask

   // sel: 0 index, 1 extra, 2 stack
   task automatic wr_ptr(input int sel, input logic [15:0] v);
      @(posedge mclk_i);
      index_we_i <= (sel == 0); extra_we_i <= (sel == 1); stack_we_i <= (sel == 2); ptr_wdata_i <= v;
      @(posedge mclk_i);
      index_we_i <= 1'b0; extra_we_i <= 1'b0; stack_we_i <= 1'b0;
      #1;
   endtask

   task automatic t_reset_views();
      `CHK(pc_o, 16'h0000)
      `CHK(index_register_o | extra_pointer_o | stack_top_pointer_o | acc_o | temp_o, 16'h0000)
      `CHK({condition_flags_o, 3'h0, bank_select_pointer_o}, 16'h0000)
   endtask

   task automatic t_direct_ext();
      next_pc_i <= 16'h2000;
      op(oag_pkg::OAG_DIRECT, 8'h45, 8'h42, 8'hEE);
      `CHK(eff_addr_o, 16'h0042)
      `CHK(pc_o, 16'h2000)
      op(oag_pkg::OAG_EXTENDED, 8'h61, 8'hAB, 8'hCD);
      `CHK(eff_addr_o, 16'hABCD)
      op(oag_pkg::OAG_DIRECT, 8'h45, 8'hFF, 8'h12);
      `CHK(eff_addr_o, 16'h00FF)
   endtask

   task automatic t_bits();
      for (int i = 0; i < 16; i++) begin
         op(oag_pkg::OAG_BITDIR, 8'hA0 + 8'(i), 8'h50 + 8'(i), 8'h00);
         rd = (8'h50 + 8'(i)) ^ 8'h3C;
         `CHK(eff_addr_o, {8'h00, 8'h50 + 8'(i)})
         `CHK(bit_sel_o, 3'(i))
         `CHK(rmw_wr_data_o, (i > 7) ? (rd | (8'h01 << i[2:0])) : (rd & ~(8'h01 << i[2:0])))
      end
   endtask

   task automatic t_index_ptr();
      wr_ptr(0, 16'h1000);
      op(oag_pkg::OAG_INDEX, 8'h46, 8'h80, 8'h00);
      `CHK(eff_addr_o, 16'h0F80)
      op(oag_pkg::OAG_INDEX, 8'h46, 8'h7F, 8'h00);
      `CHK(eff_addr_o, 16'h107F)
      wr_ptr(0, 16'hFFF0);
      op(oag_pkg::OAG_INDEX, 8'h46, 8'h20, 8'h00);
      `CHK(eff_addr_o, 16'h0010)
      wr_ptr(1, 16'hBEEF);
      `CHK(extra_pointer_o, 16'hBEEF)
      op(oag_pkg::OAG_POINTER, 8'h47, 8'h12, 8'h34);
      `CHK(eff_addr_o, 16'hBEEF)
   endtask

   task automatic t_bank();
      @(posedge mclk_i);
      bank_we_i <= 1'b1; bank_wdata_i <= 5'h1F; gpr_we_i <= 1'b1; gpr_wdata_i <= 8'h5A; opcode_i <= 8'h03;
      @(posedge mclk_i);
      bank_we_i <= 1'b0; gpr_we_i <= 1'b0;
      #1;
      `CHK(bank_select_pointer_o, 5'h1F)
      `CHK(bank_gpr_o, 8'h5A)
      op(oag_pkg::OAG_BANKREG, 8'h0F, 8'h00, 8'h00);
      `CHK(eff_addr_o, 16'h01FF)
      bank_we_i <= 1'b1; bank_wdata_i <= 5'h03;
      @(posedge mclk_i);
      bank_we_i <= 1'b0;
      op(oag_pkg::OAG_BANKREG, 8'h0A, 8'h00, 8'h00);
      `CHK(eff_addr_o, 16'h011A)
   endtask

   task automatic t_immed();
      imm_word_i <= 1'b0;
      op(oag_pkg::OAG_IMMED, 8'h04, 8'h9C, 8'h77);
      `CHK(imm_data_o, 16'h009C)
      imm_word_i <= 1'b1;
      op(oag_pkg::OAG_IMMED, 8'hE4, 8'h9C, 8'h77);
      `CHK(imm_data_o, 16'h9C77)
   endtask

   task automatic t_vector();
      wr_ptr(2, 16'h1232);
      for (int n = 0; n < 8; n++) begin
         next_pc_i <= 16'h5670 + 16'(n);
         op(oag_pkg::OAG_VECTOR, 8'hE8 + 8'(n), 8'h00, 8'h00);
         `CHK(vec_addr_hi_o, 16'hFFC0 + 16'(2 * n))
         `CHK(vec_addr_lo_o, 16'hFFC1 + 16'(2 * n))
         `CHK({push_o, push_addr_o, push_data_o}, {1'b1, 16'h1232, 16'h5670 + 16'(n)})
         vector_load_i <= 1'b1;
         @(posedge mclk_i);
         vector_load_i <= 1'b0;
         #1;
         `CHK(push_o, 1'b0)
         `CHK(pc_o, {8'hD1 + 8'(2 * n), 8'hD2 + 8'(2 * n)})
      end
   endtask

   task automatic t_rel_flags();
      next_pc_i <= 16'h2000;
      op(oag_pkg::OAG_INHERENT, 8'h00, 8'h00, 8'h00);
      branch_taken_i <= 1'b1;
      op(oag_pkg::OAG_RELATIVE, 8'hFC, 8'h80, 8'h00);
      `CHK(pc_o, 16'h1F80)
      branch_taken_i <= 1'b1;
      op(oag_pkg::OAG_RELATIVE, 8'hFC, 8'h7F, 8'h00);
      `CHK(pc_o, 16'h1FFF)
      flag_change_i <= 4'h5; flag_value_i <= 4'hF;
      op(oag_pkg::OAG_INHERENT, 8'h00, 8'h00, 8'h00);
      `CHK(condition_flags_o, 8'h05)
      flag_change_i <= 4'hA; flag_value_i <= 4'h8;
      op(oag_pkg::OAG_INHERENT, 8'h00, 8'h00, 8'h00);
      `CHK(condition_flags_o, 8'h0D)
   endtask

   task automatic t_acc();
      @(posedge mclk_i);
      acc_hi_we_i <= 1'b1; acc_lo_we_i <= 1'b1; acc_wdata_i <= 16'h1234;
      @(posedge mclk_i);
      acc_hi_we_i <= 1'b0; temp_hi_copy_i <= 1'b1; temp_lo_copy_i <= 1'b1; acc_wdata_i <= 16'h00FF;
      @(posedge mclk_i);
      acc_lo_we_i <= 1'b0; temp_hi_copy_i <= 1'b0; temp_lo_copy_i <= 1'b0;
      #1;
      `CHK(acc_o, 16'h12FF)
      `CHK(temp_o, 16'h1234)
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {exec_i, imm_word_i, acc_hi_we_i, acc_lo_we_i, temp_hi_copy_i, temp_lo_copy_i, index_we_i} = '0;
      {extra_we_i, stack_we_i, bank_we_i, gpr_we_i, branch_taken_i, vector_load_i} = '0;
      {opcode_i, operand1_i, operand2_i, gpr_wdata_i, next_pc_i, acc_wdata_i, ptr_wdata_i} = '0;
      {bank_wdata_i, flag_change_i, flag_value_i} = '0;
      mode_i = oag_pkg::OAG_INHERENT;
      sys_rst_i = 1'b1;
      miscompares = 0;
      tests_run = 0;
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      t_reset_views();
      t_direct_ext();
      t_bits();
      t_index_ptr();
      t_bank();
      t_immed();
      t_vector();
      t_rel_flags();
      t_acc();
      final_report();
   end

   // Whole run is about 110 cycles; this span of 5000 cycles leaves a wide margin
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
endmodule
